// File: rtl/spd_link.sv
// Single-pin debug link slave: receiver, packet engine, transmitter and register slave.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - Characters use one start bit, eight data bits LSB first, one stop bit.
// - Master starts every exchange and sets rate; device only answers commands.
// - Packet is sync 0x55, command byte, optional length and data, two CRC bytes.
// - Command top bit set means length and data fields follow.
// - Responses set bit six of the code byte; commands keep it clear.
// - A received CRC of 0x0000 skips the CRC check.
// - CRC covers command, length, data; reflected poly 0x8408, start 0x0000.
// - Bit rate is re-measured from every sync byte and used for the reply.
// - Wait guard time, reset to 128 bits, before driving the line.
// - Release the line right after the last stop bit.
// - Enabling the link sets the halt bit; a halt command loads it from bit 0 of its first data byte.
// - Pin low for 100 ms disables the link and resets the device.
// - Disable command is acknowledged first, then the link turns off.
// - Pin low for 20 ms resets the debug slave like disable plus enable, but keeps a pending reset-command request set.
// - After the two-pin command, replies go on the separate output pin.
// - While active, pin reset is ignored; only the reset command or a 100 ms low resets.
// - Tune value equals eight oscillator-to-bit-rate ratio and is reported.
// - An active link forces the system clocks on.
// - The link runs from the fast oscillator, started when enabled.
// - Service-bus traffic goes through a synchronising bus master outside.
// - A CRC mismatch draws a negative reply, as do halt, reset or guard without data and memory commands after a busy error.
// - Unknown commands draw a negative reply.
module spd_link #(
	parameter int SLV_RST_CYC = spd_pkg::SLV_RST_CYC,
	parameter int DIS_CYC = spd_pkg::DIS_CYC,
	parameter int ENA_SYNC_CYC = spd_pkg::ENA_SYNC_CYC,
	// Identity value is arbitrary.
	parameter logic [31:0] IDCODE = 32'h1234_5001
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus.
	input wire spd_pkg::spd_axi_req_s axi_req,
	output spd_pkg::spd_axi_rsp_s axi_rsp,
	// Link pins.
	input wire logic reset_pin_in,
	output spd_pkg::spd_pin_o_s pin_o,
	// System controls.
	output spd_pkg::spd_sys_o_s sys_o,
	// Service-bus byte stream towards the clock-crossing bus master.
	output spd_pkg::spd_svc_s svc_o,
	input wire logic svc_ready
);
	import spd_pkg::*;

	logic pin_r, pin_prev_r, enabled_r, two_pin_r, halt_r, sys_rst_cmd_r, dev_rst_r, dis_pend_r;
	logic [CNT_W-1:0] low_cnt_r, rx_cnt_r, tune_r, tx_cnt_r;
	logic [7:0] guard_r, rx_sh_r, gcnt_r, cmd_r, crc_lo_r, d0_r, rsp_code_r;
	logic [2:0] edge_n_r;
	logic [3:0] rx_bn_r, tx_bn_r, tx_idx_r;
	logic [15:0] crc_r, len_r, data_n_r, tx_crc_r;
	logic [31:0] rsp_data_r;
	logic rsp_long_r, svc_err_r;
	logic [9:0] tx_sh_r;
	spd_rx_e rx_st_r;
	spd_pk_e pk_st_r;
	spd_tx_e tx_st_r;
	spd_svc_s svc_r;

	// Pin edge and long-low detection.
	wire fall = pin_prev_r & ~pin_r;
	wire slv_rst = enabled_r & ~pin_r & (low_cnt_r == CNT_W'(SLV_RST_CYC - 1));
	wire dis_evt = enabled_r & ~pin_r & (low_cnt_r == CNT_W'(DIS_CYC - 1));
	wire tx_busy = tx_st_r != TX_IDLE;
	wire [CNT_W-1:0] bit_per = {3'h0, tune_r[CNT_W-1:3]};
	wire [CNT_W-1:0] half_per = {4'h0, tune_r[CNT_W-1:4]};
	wire sync_done = (rx_st_r == RX_SYNC) & fall & (edge_n_r == 3'h4);
	wire [CNT_W-1:0] sync_len = rx_cnt_r + CNT_W'(1);
	wire ena_ok = (sync_len >= CNT_W'(ENA_SYNC_CYC / 2)) & (sync_len <= CNT_W'(ENA_SYNC_CYC * 2));
	wire line_enable = sync_done & ~enabled_r & ena_ok;
	wire [CNT_W-1:0] rx_tgt = (rx_bn_r == 4'h0) ? half_per : bit_per - CNT_W'(1);
	wire rx_tick = (rx_st_r == RX_BITS) & (rx_cnt_r == rx_tgt);
	wire rx_byte_v = rx_tick & (rx_bn_r == FRAME_BITS) & pin_r;
	wire [7:0] rx_byte = rx_sh_r;
	wire exec = rx_byte_v & (pk_st_r == PK_CRCH);
	wire [15:0] rx_crc = {rx_byte, crc_lo_r};
	wire crc_ok = (rx_crc == CRC_SKIP) | (rx_crc == crc_r);
	wire has_d = data_n_r != 16'h0;
	wire mem_cmd = (cmd_r == CMD_MEM_WR) | (cmd_r == CMD_MEM_RD);
	wire svc_load = rx_byte_v & (pk_st_r == PK_DATA) & mem_cmd & enabled_r;
	wire svc_busy = svc_r.valid & ~svc_ready;

	always_ff @(posedge aclk)
	begin
		pin_r <= aresetn ? reset_pin_in : 1'b1;
		pin_prev_r <= aresetn ? pin_r : 1'b1;
		if (!aresetn || pin_r)
			low_cnt_r <= '0;
		else if (low_cnt_r != CNT_W'(DIS_CYC))
			low_cnt_r <= low_cnt_r + CNT_W'(1);
	end

	// Character receiver; the sync byte is timed from its first to fifth falling edge.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || slv_rst || tx_busy || exec)
		begin
			rx_st_r <= RX_IDLE;
			rx_cnt_r <= '0;
			edge_n_r <= '0;
			rx_bn_r <= '0;
		end
		else
		begin
			case (rx_st_r)
				RX_IDLE:
				begin
					rx_cnt_r <= '0;
					edge_n_r <= 3'h1;
					if (fall)
						rx_st_r <= RX_SYNC;
				end
				RX_SYNC:
				begin
					rx_cnt_r <= rx_cnt_r + CNT_W'(1);
					if (fall)
						edge_n_r <= edge_n_r + 3'h1;
					if (sync_done)
						rx_st_r <= enabled_r ? RX_WAIT : RX_IDLE;
					// A sync slower than the slowest legal rate is dropped, so stray edges
					// cannot leave the receiver stuck counting.
					else if (rx_cnt_r == CNT_W'(ENA_SYNC_CYC * 2))
						rx_st_r <= RX_IDLE;
				end
				RX_WAIT:
				begin
					rx_cnt_r <= '0;
					rx_bn_r <= '0;
					if (fall)
						rx_st_r <= RX_BITS;
				end
				RX_BITS:
				begin
					rx_cnt_r <= rx_tick ? '0 : rx_cnt_r + CNT_W'(1);
					if (rx_tick)
					begin
						rx_bn_r <= rx_bn_r + 4'h1;
						if ((rx_bn_r == 4'h0 && pin_r) || rx_bn_r == FRAME_BITS)
							rx_st_r <= RX_WAIT;
					end
				end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tune_r <= CNT_W'(ENA_SYNC_CYC);
		else if (sync_done)
			tune_r <= sync_len;
		if (rx_tick && rx_bn_r != 4'h0 && rx_bn_r != FRAME_BITS)
			rx_sh_r <= {pin_r, rx_sh_r[7:1]};
	end

	// Packet parser: command, optional length and data, then CRC.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sync_done || slv_rst)
		begin
			pk_st_r <= PK_CMD;
			crc_r <= CRC_INIT;
			data_n_r <= '0;
		end
		else if (rx_byte_v)
		begin
			if (pk_st_r != PK_CRCL && pk_st_r != PK_CRCH)
				crc_r <= spd_crc_byte(crc_r, rx_byte);
			case (pk_st_r)
				PK_CMD:
				begin
					cmd_r <= rx_byte;
					pk_st_r <= rx_byte[BIT_LONG] ? PK_LENH : PK_CRCL;
				end
				PK_LENH:
				begin
					len_r[15:8] <= rx_byte;
					pk_st_r <= PK_LENL;
				end
				PK_LENL:
				begin
					len_r[7:0] <= rx_byte;
					pk_st_r <= ({len_r[15:8], rx_byte} == 16'h0) ? PK_CRCL : PK_DATA;
				end
				PK_DATA:
				begin
					if (data_n_r == 16'h0)
						d0_r <= rx_byte;
					data_n_r <= data_n_r + 16'h1;
					if (data_n_r == len_r - 16'h1)
						pk_st_r <= PK_CRCL;
				end
				PK_CRCL:
				begin
					crc_lo_r <= rx_byte;
					pk_st_r <= PK_CRCH;
				end
				PK_CRCH: pk_st_r <= PK_CMD;
				default: pk_st_r <= PK_CMD;
			endcase
		end
	end

	// Service-bus bytes; a byte arriving before the last was taken is a busy error.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			svc_r <= '0;
			svc_err_r <= 1'b0;
		end
		else
		begin
			if (svc_r.valid && svc_ready)
				svc_r.valid <= 1'b0;
			if (sync_done)
				svc_err_r <= 1'b0;
			if (svc_load && svc_busy)
				svc_err_r <= 1'b1;
			else if (svc_load)
				svc_r <= '{valid: 1'b1, write: cmd_r == CMD_MEM_WR, first: ~has_d, data: rx_byte};
		end
	end

	// Command decode at the end of a packet.
	logic [7:0] rsp_c;
	logic long_c, ok_c;
	logic [31:0] dat_c;
	always_comb
	begin
		ok_c = 1'b1;
		long_c = 1'b0;
		dat_c = '0;
		case (cmd_r)
			CMD_AYA, CMD_DISABLE, CMD_TWO_PIN: ok_c = 1'b1;
			CMD_ID:
			begin
				long_c = 1'b1;
				dat_c = IDCODE;
			end
			CMD_TUNE:
			begin
				long_c = 1'b1;
				dat_c = 32'(tune_r);
			end
			CMD_HALT, CMD_RESET, CMD_GUARD: ok_c = has_d;
			CMD_MEM_WR, CMD_MEM_RD: ok_c = ~svc_err_r;
			default: ok_c = 1'b0;
		endcase
		ok_c = ok_c & crc_ok;
		rsp_c = ~ok_c ? RSP_NEG : (cmd_r == CMD_ID) ? RSP_ID : (cmd_r == CMD_TUNE) ? RSP_TUNE : RSP_ACK;
	end
	wire run = exec & ok_c & enabled_r;

	// Link state, halt, guard and reset controls.
	logic ctrl_wr, ctrl_en;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enabled_r <= 1'b0;
			two_pin_r <= 1'b0;
			halt_r <= 1'b0;
			guard_r <= GUARD_MAX;
			dis_pend_r <= 1'b0;
			sys_rst_cmd_r <= 1'b0;
			dev_rst_r <= 1'b0;
		end
		else
		begin
			dev_rst_r <= dis_evt;
			if (line_enable || slv_rst || (ctrl_wr && ctrl_en && !enabled_r))
			begin
				enabled_r <= 1'b1;
				halt_r <= 1'b1;
				guard_r <= GUARD_MAX;
				two_pin_r <= 1'b0;
				dis_pend_r <= 1'b0;
			end
			else if (dis_evt || (ctrl_wr && !ctrl_en) || (dis_pend_r && !tx_busy))
			begin
				enabled_r <= 1'b0;
				two_pin_r <= 1'b0;
				dis_pend_r <= 1'b0;
				sys_rst_cmd_r <= 1'b0;
			end
			else if (run)
			begin
				if (cmd_r == CMD_DISABLE)
					dis_pend_r <= 1'b1;
				if (cmd_r == CMD_TWO_PIN)
					two_pin_r <= 1'b1;
				if (cmd_r == CMD_HALT)
					halt_r <= d0_r[0];
				if (cmd_r == CMD_RESET)
					sys_rst_cmd_r <= d0_r[0];
				if (cmd_r == CMD_GUARD)
					guard_r <= (d0_r == 8'h0 || d0_r > GUARD_MAX) ? GUARD_MAX : d0_r;
			end
		end
	end

	// Transmitter: guard time, then sync, code, optional length and data, CRC low then high.
	wire [3:0] tx_n = rsp_long_r ? TX_N_LONG : TX_N_SHORT;
	wire [1:0] dsel = tx_idx_r[1:0];
	wire [7:0] tx_dat = rsp_data_r[(5'd31 - {dsel, 3'h0}) -: 8];
	wire [7:0] tx_byte = (tx_idx_r == 4'h0) ? SYNC_BYTE : (tx_idx_r == 4'h1) ? rsp_code_r :
		(tx_idx_r == tx_n - 4'h2) ? tx_crc_r[7:0] : (tx_idx_r == tx_n - 4'h1) ? tx_crc_r[15:8] :
		(tx_idx_r == 4'h2) ? RSP_DLEN[15:8] : (tx_idx_r == 4'h3) ? RSP_DLEN[7:0] : tx_dat;
	wire tx_bit_end = tx_cnt_r == bit_per - CNT_W'(1);
	wire tx_load = (tx_st_r == TX_GUARD && tx_bit_end && gcnt_r == 8'h1) ||
		(tx_st_r == TX_BITS && tx_bit_end && tx_bn_r == FRAME_BITS && tx_idx_r != tx_n);
	wire tx_last = tx_st_r == TX_BITS && tx_bit_end && tx_bn_r == FRAME_BITS && tx_idx_r == tx_n;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || slv_rst || dis_evt)
		begin
			tx_st_r <= TX_IDLE;
			tx_sh_r <= 10'h3ff;
			tx_cnt_r <= '0;
		end
		else
		begin
			tx_cnt_r <= (tx_st_r == TX_IDLE || tx_bit_end) ? '0 : tx_cnt_r + CNT_W'(1);
			if (exec && enabled_r)
			begin
				tx_st_r <= TX_GUARD;
				gcnt_r <= guard_r;
				tx_idx_r <= '0;
				tx_crc_r <= CRC_INIT;
				rsp_code_r <= rsp_c;
				rsp_long_r <= long_c;
				rsp_data_r <= dat_c;
			end
			else if (tx_st_r == TX_GUARD && tx_bit_end)
				gcnt_r <= gcnt_r - 8'h1;
			if (tx_load)
			begin
				tx_st_r <= TX_BITS;
				tx_sh_r <= {1'b1, tx_byte, 1'b0};
				tx_bn_r <= '0;
				tx_idx_r <= tx_idx_r + 4'h1;
				if (tx_idx_r != 4'h0 && tx_idx_r < tx_n - 4'h2)
					tx_crc_r <= spd_crc_byte(tx_crc_r, tx_byte);
			end
			else if (tx_last)
			begin
				tx_st_r <= TX_IDLE;
				tx_sh_r <= 10'h3ff;
			end
			else if (tx_st_r == TX_BITS && tx_bit_end)
			begin
				tx_sh_r <= {1'b1, tx_sh_r[9:1]};
				tx_bn_r <= tx_bn_r + 4'h1;
			end
		end
	end

	wire tx_drive = tx_st_r == TX_BITS;
	assign pin_o.reset_pin_out = tx_sh_r[0];
	assign pin_o.reset_pin_oe_n = ~(tx_drive & ~two_pin_r);
	assign pin_o.debug_tx_pin_out = tx_sh_r[0];
	assign pin_o.debug_tx_pin_oe_n = ~(enabled_r & two_pin_r);

	assign sys_o.link_enabled = enabled_r;
	assign sys_o.cpu_halt = halt_r;
	assign sys_o.sys_reset_req = sys_rst_cmd_r | dev_rst_r;
	assign sys_o.clk_force_on = enabled_r;
	assign sys_o.osc_enable = enabled_r;
	assign sys_o.pin_reset_n = enabled_r | pin_r;
	assign svc_o = svc_r;

	// Register slave.
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	wire wr_go = aw_got_r & w_got_r & ~bvalid_r;
	wire rd_go = axi_req.arvalid & ~rvalid_r;
	wire wr_map = (awaddr_r == REG_CTRL) | (awaddr_r == REG_STAT) | (awaddr_r == REG_TUNE) |
		(awaddr_r == REG_GUARD);
	wire rd_map = (axi_req.araddr == REG_CTRL) | (axi_req.araddr == REG_STAT) |
		(axi_req.araddr == REG_TUNE) | (axi_req.araddr == REG_GUARD);
	wire [31:0] stat_w = {27'h0, svc_err_r, tx_busy, halt_r, two_pin_r, enabled_r};
	wire [31:0] rd_mux = (axi_req.araddr == REG_CTRL) ? {31'h0, enabled_r} :
		(axi_req.araddr == REG_STAT) ? stat_w : (axi_req.araddr == REG_TUNE) ? 32'(tune_r) :
		(axi_req.araddr == REG_GUARD) ? {24'h0, guard_r} : 32'h0;
	assign ctrl_wr = wr_go & (awaddr_r == REG_CTRL) & wstrb_r[0];
	assign ctrl_en = wdata_r[CTRL_EN];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			rvalid_r <= 1'b0;
		end
		else
		begin
			if (axi_req.awvalid && axi_rsp.awready)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= axi_req.awaddr;
			end
			if (axi_req.wvalid && axi_rsp.wready)
			begin
				w_got_r <= 1'b1;
				wdata_r <= axi_req.wdata;
				wstrb_r <= axi_req.wstrb;
			end
			if (wr_go)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_map ? RESP_OKAY : RESP_DECERR;
			end
			else if (bvalid_r && axi_req.bready)
				bvalid_r <= 1'b0;
			if (rd_go)
			begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= rd_map ? RESP_OKAY : RESP_DECERR;
			end
			else if (rvalid_r && axi_req.rready)
				rvalid_r <= 1'b0;
		end
	end

	assign axi_rsp.awready = ~aw_got_r & ~bvalid_r;
	assign axi_rsp.wready = ~w_got_r & ~bvalid_r;
	assign axi_rsp.bvalid = bvalid_r;
	assign axi_rsp.bresp = bresp_r;
	assign axi_rsp.arready = ~rvalid_r;
	assign axi_rsp.rvalid = rvalid_r;
	assign axi_rsp.rdata = rdata_r;
	assign axi_rsp.rresp = rresp_r;
endmodule : spd_link

// File: common/spd_pkg.sv
// Shared constants, types and the CRC helper for the single-pin debug link.
package spd_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int T_SLV_RST_MS = 20;
	localparam int T_DIS_MS = 100;
	localparam int ENA_BAUD_HZ = 1000;
	localparam int SLV_RST_CYC = CLK_HZ / 1000 * T_SLV_RST_MS;
	localparam int DIS_CYC = CLK_HZ / 1000 * T_DIS_MS;
	localparam int ENA_SYNC_CYC = CLK_HZ / ENA_BAUD_HZ * 8;
	localparam int CNT_W = 24;
	localparam logic [7:0] SYNC_BYTE = 8'h55;
	localparam int BIT_LONG = 7;
	localparam int BIT_RSP = 6;
	localparam logic [7:0] GUARD_MAX = 8'h80;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [15:0] CRC_SKIP = 16'h0000;
	localparam logic [7:0] CMD_AYA = 8'h01;
	localparam logic [7:0] CMD_ID = 8'h02;
	localparam logic [7:0] CMD_TUNE = 8'h04;
	localparam logic [7:0] CMD_DISABLE = 8'h07;
	localparam logic [7:0] CMD_TWO_PIN = 8'h08;
	localparam logic [7:0] CMD_MEM_WR = 8'h80;
	localparam logic [7:0] CMD_MEM_RD = 8'h81;
	localparam logic [7:0] CMD_HALT = 8'h82;
	localparam logic [7:0] CMD_RESET = 8'h83;
	localparam logic [7:0] CMD_GUARD = 8'h84;
	localparam logic [7:0] RSP_ACK = 8'h40;
	localparam logic [7:0] RSP_NEG = 8'h41;
	localparam logic [7:0] RSP_ID = 8'hc0;
	localparam logic [7:0] RSP_TUNE = 8'hc3;
	localparam logic [15:0] RSP_DLEN = 16'h0004;
	localparam logic [3:0] TX_N_SHORT = 4'h4;
	localparam logic [3:0] TX_N_LONG = 4'ha;
	localparam logic [3:0] FRAME_BITS = 4'h9;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_TUNE = 8'h08;
	localparam logic [7:0] REG_GUARD = 8'h0c;
	localparam int CTRL_EN = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {RX_IDLE, RX_SYNC, RX_WAIT, RX_BITS} spd_rx_e;
	typedef enum logic [2:0] {PK_CMD, PK_LENH, PK_LENL, PK_DATA, PK_CRCL, PK_CRCH} spd_pk_e;
	typedef enum logic [1:0] {TX_IDLE, TX_GUARD, TX_BITS} spd_tx_e;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} spd_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} spd_axi_rsp_s;

	typedef struct packed {
		logic reset_pin_out;
		logic reset_pin_oe_n;
		logic debug_tx_pin_out;
		logic debug_tx_pin_oe_n;
	} spd_pin_o_s;

	typedef struct packed {
		logic link_enabled;
		logic cpu_halt;
		logic sys_reset_req;
		logic clk_force_on;
		logic osc_enable;
		logic pin_reset_n;
	} spd_sys_o_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic first;
		logic [7:0] data;
	} spd_svc_s;

	function automatic logic [15:0] spd_crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : spd_crc_byte
endpackage : spd_pkg

// File: tb/spd_link_sva.sv
// Property checker for the single-pin debug link, bound to its top module.
`timescale 1ns/1ns
module spd_link_chk
	import spd_pkg::*;
#(
	parameter int DIS_CYC = spd_pkg::DIS_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus.
	input wire spd_pkg::spd_axi_req_s axi_req,
	input wire spd_pkg::spd_axi_rsp_s axi_rsp,
	// Pins, system controls and service stream.
	input wire logic reset_pin_in,
	input wire spd_pkg::spd_pin_o_s pin_o,
	input wire spd_pkg::spd_sys_o_s sys_o,
	input wire spd_pkg::spd_svc_s svc_o,
	input wire logic svc_ready
);
	// The margin covers the pin synchroniser and the disable step.
	localparam logic [23:0] LOW_MAX = 24'(DIS_CYC + 8);
	logic [23:0] low_cnt_r;
	logic [23:0] low_cnt_nxt;

	assign low_cnt_nxt = reset_pin_in ? 24'h0 : (low_cnt_r == LOW_MAX ? low_cnt_r : low_cnt_r + 24'h1);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			low_cnt_r <= 24'h0;
		else
			low_cnt_r <= low_cnt_nxt;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_halt_on_enable: assert property ($rose(sys_o.link_enabled) |-> sys_o.cpu_halt)
		else $error("halt not set when the link came up");
	a_clk_forced: assert property (sys_o.clk_force_on == sys_o.link_enabled)
		else $error("system clock force differs from link state");
	a_osc_started: assert property (sys_o.link_enabled |-> sys_o.osc_enable)
		else $error("oscillator off while link enabled");
	a_pin_reset_masked: assert property (sys_o.link_enabled |-> sys_o.pin_reset_n)
		else $error("pin reset passed through while link enabled");
	a_drive_when_on: assert property ($fell(pin_o.reset_pin_oe_n) |-> sys_o.link_enabled)
		else $error("shared pin driven while link disabled");
	a_release_on_stop: assert property ($rose(pin_o.reset_pin_oe_n) |-> $past(pin_o.reset_pin_out))
		else $error("shared pin released after a low bit");
	a_one_pin_only: assert property (!pin_o.reset_pin_oe_n |-> pin_o.debug_tx_pin_oe_n)
		else $error("both output pins driven");
	a_long_low_off: assert property (low_cnt_r == LOW_MAX |-> !sys_o.link_enabled)
		else $error("link still enabled after long low");
	a_bit_held: assert property ((!pin_o.reset_pin_oe_n && $changed(pin_o.reset_pin_out))
		|=> $stable(pin_o.reset_pin_out) [*3])
		else $error("reply bit shorter than four cycles");
	a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read data not returned one cycle after address");
endmodule : spd_link_chk

bind spd_link spd_link_chk #(.DIS_CYC(DIS_CYC)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .reset_pin_in(reset_pin_in), .pin_o(pin_o),
	.sys_o(sys_o), .svc_o(svc_o), .svc_ready(svc_ready));

// File: tb/spd_master.sv
// Behavioural debug master that drives the shared line and collects replies.
`timescale 1ns/1ns
module spd_master
	import spd_pkg::*;
(
	// Clock.
	input wire logic aclk,
	// Levels seen by the master.
	input wire logic line_in,
	input wire logic tx_in,
	// Master drive; high means released to the pull-up.
	output logic line_out
);
	int per = 16;
	bit two_pin = 0;
	bit crc_ok;
	longint cyc = 0;
	longint t_end;
	longint t_rx;
	logic rx;

	assign rx = two_pin ? tx_in : line_in;
	initial line_out = 1'b1;
	always @(posedge aclk) cyc <= cyc + 1;

	function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		return c;
	endfunction : crc_add

	task automatic send_byte(input logic [7:0] b, input int p);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_out <= f[i];
			repeat (p) @(posedge aclk);
		end
	endtask : send_byte

	// Mode 1 sends a zero CRC, mode 2 a corrupted one.
	task automatic send_pkt(input logic [7:0] q[$], input int mode);
		logic [15:0] c;
		c = 16'h0000;
		foreach (q[i]) c = crc_add(c, q[i]);
		if (mode == 1) c = 16'h0000;
		if (mode == 2) c = c ^ 16'h0001;
		send_byte(SYNC_BYTE, per);
		foreach (q[i]) send_byte(q[i], per);
		send_byte(c[7:0], per);
		send_byte(c[15:8], per);
		t_end = cyc;
	endtask : send_pkt

	// Samples mid-bit; ok stays low on silence or a missing stop bit.
	task automatic recv_byte(input int lim, output logic [7:0] b, output bit ok);
		int n;
		n = 0;
		ok = 0;
		while (rx !== 1'b0 && n < lim)
		begin
			@(posedge aclk);
			n++;
		end
		if (n >= lim)
			return;
		t_rx = cyc;
		repeat (per / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (per) @(posedge aclk);
			b[i] = rx;
		end
		repeat (per) @(posedge aclk);
		ok = rx === 1'b1;
	endtask : recv_byte

	task automatic recv_pkt(input int lim, output logic [7:0] q[$]);
		logic [7:0] b;
		logic [15:0] c;
		bit ok;
		int len;
		longint t0;
		q = {};
		len = 4;
		recv_byte(lim, b, ok);
		t0 = t_rx;
		while (ok)
		begin
			q.push_back(b);
			if (q.size() == 2 && b[7])
				len = 6;
			if (q.size() == 4 && len == 6)
				len = 6 + {q[2], q[3]};
			if (q.size() == len)
				break;
			recv_byte(8 * per, b, ok);
		end
		t_rx = t0;
		c = 16'h0000;
		for (int i = 1; i + 2 < q.size(); i++)
			c = crc_add(c, q[i]);
		crc_ok = q.size() >= 4 && {q[q.size() - 1], q[q.size() - 2]} === c;
	endtask : recv_pkt
endmodule : spd_master

// File: tb/tb_top.sv
// Self-checking bench for the single-pin debug link.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); \
			bad_count++; \
		end \
	end
module tb_top;
	import spd_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	spd_axi_req_s req = '0;
	spd_axi_rsp_s axi_rsp;
	spd_pin_o_s pin_o;
	spd_sys_o_s sys_o;
	localparam int ENA_CYC = 400;
	logic svc_ready = 1'b1;
	spd_svc_s svc_o;
	spd_svc_s svc_seen = '0;
	logic m_out;
	logic hold_n = 1'b1;
	logic line;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	bit seen;
	logic [7:0] rq[$];
	logic [31:0] rd;
	logic [1:0] rr;

	always #4 aclk = ~aclk;
	// Pull-up line: whoever drives low wins.
	assign line = m_out & hold_n & (pin_o.reset_pin_oe_n | pin_o.reset_pin_out);

	spd_link #(.SLV_RST_CYC(200), .DIS_CYC(1000), .ENA_SYNC_CYC(ENA_CYC)) uut (.aclk(aclk),
		.aresetn(aresetn), .axi_req(req), .axi_rsp(axi_rsp), .reset_pin_in(line),
		.pin_o(pin_o), .sys_o(sys_o), .svc_o(svc_o), .svc_ready(svc_ready));
	spd_master m (.aclk(aclk), .line_in(line), .tx_in(pin_o.debug_tx_pin_out), .line_out(m_out));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	always @(posedge aclk)
	begin
		if (svc_o.valid && svc_ready)
			svc_seen <= svc_o;
	end

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (axi_rsp.awready)
				req.awvalid <= 1'b0;
			if (axi_rsp.wready)
				req.wvalid <= 1'b0;
		end
		while (axi_rsp.bvalid !== 1'b1);
		r = axi_rsp.bresp;
		req.bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (axi_rsp.arready)
				req.arvalid <= 1'b0;
		end
		while (axi_rsp.rvalid !== 1'b1);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		req.rready <= 1'b0;
	endtask : axi_rd

	// A guard of zero skips the timing check for replies whose guard may change.
	task automatic xfer(input logic [7:0] q[$], input int mode, input logic [7:0] code, input int gd);
		longint gap;
		m.send_pkt(q, mode);
		m.recv_pkt((gd == 0 ? 136 : gd + 8) * m.per, rq);
		gap = m.t_rx - m.t_end;
		`CHK("sync", SYNC_BYTE, rq[0])
		`CHK("code", code, rq[1])
		`CHK("reply crc", 1'b1, m.crc_ok)
		if (gd != 0)
			`CHK("guard", 1'b1, gap >= (gd - 1) * m.per && gap <= (gd + 1) * m.per)
		repeat (4 * m.per) @(posedge aclk);
	endtask : xfer

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(REG_CTRL, rd, rr);
		`CHK("ctrl", 32'h0, rd)
		axi_rd(REG_GUARD, rd, rr);
		`CHK("guard reg", 32'h80, rd)
		axi_wr(REG_TUNE, 32'h1, rr);
		`CHK("ro write", RESP_OKAY, rr)
		axi_rd(REG_TUNE, rd, rr);
		`CHK("tune reset", 32'(ENA_CYC), rd)
		axi_rd(8'h10, rd, rr);
		`CHK("unmapped", RESP_DECERR, rr)
		// A slow packet could pass for the enable pattern, so this one goes out fast.
		m.per = 8;
		m.send_pkt('{CMD_AYA}, 0);
		m.recv_pkt(136 * 16, rq);
		m.per = 16;
		`CHK("silent off", 32'h0, rq.size())
		$display("test registers done");
		m.send_byte(SYNC_BYTE, ENA_CYC / 8);
		repeat (32) @(posedge aclk);
		`CHK("enabled", 1'b1, sys_o.link_enabled)
		`CHK("halt set", 1'b1, sys_o.cpu_halt)
		`CHK("osc on", 1'b1, sys_o.osc_enable)
		xfer('{CMD_AYA}, 0, RSP_ACK, 128);
		axi_rd(REG_TUNE, rd, rr);
		`CHK("tune", 32'h80, rd)
		m.per = 8;
		xfer('{CMD_TUNE}, 0, RSP_TUNE, 128);
		`CHK("tune data", 48'h0004_0000_0040, {rq[2], rq[3], rq[4], rq[5], rq[6], rq[7]})
		m.per = 16;
		xfer('{CMD_AYA}, 2, RSP_NEG, 128);
		xfer('{CMD_AYA}, 1, RSP_ACK, 128);
		xfer('{8'h3f}, 0, RSP_NEG, 128);
		$display("test commands done");
		xfer('{CMD_HALT, 8'h00, 8'h01, 8'h00}, 0, RSP_ACK, 128);
		`CHK("halt clear", 1'b0, sys_o.cpu_halt)
		xfer('{CMD_GUARD, 8'h00, 8'h01, 8'h04}, 0, RSP_ACK, 0);
		xfer('{CMD_AYA}, 0, RSP_ACK, 4);
		xfer('{CMD_RESET, 8'h00, 8'h01, 8'h01}, 0, RSP_ACK, 4);
		`CHK("reset cmd", 1'b1, sys_o.sys_reset_req)
		xfer('{CMD_RESET, 8'h00, 8'h01, 8'h00}, 0, RSP_ACK, 4);
		xfer('{CMD_MEM_WR, 8'h00, 8'h01, 8'ha5}, 0, RSP_ACK, 4);
		`CHK("svc byte", 10'h3a5, {svc_seen.write, svc_seen.first, svc_seen.data})
		hold_n <= 1'b0;
		repeat (300) @(posedge aclk);
		hold_n <= 1'b1;
		repeat (32) @(posedge aclk);
		`CHK("slave halt", 1'b1, sys_o.cpu_halt)
		`CHK("slave on", 1'b1, sys_o.link_enabled)
		axi_rd(REG_GUARD, rd, rr);
		`CHK("guard back", 32'h80, rd)
		$display("test halt and guard done");
		m.two_pin = 1;
		xfer('{CMD_TWO_PIN}, 0, RSP_ACK, 128);
		`CHK("tx pin on", 1'b0, pin_o.debug_tx_pin_oe_n)
		xfer('{CMD_DISABLE}, 0, RSP_ACK, 128);
		`CHK("cmd off", 1'b0, sys_o.link_enabled)
		m.two_pin = 0;
		m.send_byte(SYNC_BYTE, ENA_CYC / 8);
		repeat (32) @(posedge aclk);
		hold_n <= 1'b0;
		seen = 0;
		repeat (1100)
		begin
			@(posedge aclk);
			if (sys_o.sys_reset_req === 1'b1)
				seen = 1;
		end
		`CHK("long low off", 1'b0, sys_o.link_enabled)
		`CHK("device reset", 1'b1, seen)
		`CHK("pin reset back", 1'b0, sys_o.pin_reset_n)
		hold_n <= 1'b1;
		$display("test disable done");
		wrap_up();
	end
endmodule : tb_top
